// ### src/acq_rec_pkg.sv
/*
 * Package for the acquisition recording control block: register map, field
 * positions, reset values, modes, record tags and timing counts.
 * Assumes a 250 MHz core clock and 32-bit APB.
 */
package acq_rec_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_DURATION = 8'h10;
    localparam logic [7:0] REG_HISTORY = 8'h14;
    localparam logic [7:0] REG_SWEEP_LEN = 8'h18;
    localparam logic [7:0] REG_RATE = 8'h1C;
    localparam logic [7:0] REG_SWITCHES = 8'h20;
    // control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_MODE_HI = 6;
    localparam int CTRL_FAST_REQ = 8;
    // rate fields: slow divider in [15:0], fast divider in [31:16]
    localparam int RATE_SLOW_LO = 0;
    localparam int RATE_FAST_LO = 16;
    // interrupt event bits
    localparam int EV_DONE = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_SWEEP_DROP = 2;
    localparam int EV_RESUME = 3;
    localparam int EV_RATE_ERR = 4;
    localparam int EV_N = 5;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] DURATION_RST = 32'h0000_0000;
    localparam logic [31:0] HISTORY_RST = 32'h0000_0000;
    localparam logic [31:0] SWEEP_LEN_RST = 32'h0000_0000;
    localparam logic [31:0] RATE_RST = 32'h0002_0004;
    // limits
    localparam int unsigned SWITCH_PER_SEC = 400;
    localparam int unsigned SWITCH_MAX = 200_000;
    localparam int unsigned SWITCH_WIN_CYC = CLK_HZ;
    localparam int unsigned CH_CEIL_SPS = 20_000_000;
    localparam logic [15:0] SLOW_DIV_MIN = 16'((CLK_HZ + CH_CEIL_SPS - 1) / CH_CEIL_SPS);
    localparam logic [15:0] SLOW_FAST_RATIO = 16'h0002;

    typedef enum logic [6:0] {
        MODE_MULTI = 7'h01,
        MODE_SLOWFAST = 7'h02,
        MODE_STANDARD = 7'h04,
        MODE_CIRCULAR = 7'h08,
        MODE_TIMED = 7'h10,
        MODE_STOPTRIG = 7'h20,
        MODE_IDLE_SEL = 7'h40
    } mode_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_SUSPEND = 4'h4,
        ST_DONE = 4'h8
    } state_t;

    // tag carried in the top bits of each stream word
    typedef enum logic [1:0] {
        TAG_SAMPLE = 2'h0,
        TAG_TRIGGER = 2'h1,
        TAG_OVR_BEGIN = 2'h2,
        TAG_OVR_END = 2'h3
    } tag_t;

    typedef struct packed {
        tag_t tag;
        logic [29:0] payload;
    } word_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
endpackage

// ### src/acq_rec_ctrl.sv
/*
 * Acquisition recording control: mode sequencing, continuous recording via
 * an internal FIFO with suspend/resume, sweep overflow markers, slow/fast
 * rate switching limits, APB register file and interrupt.
 * Assumes sample/trigger inputs are on core_clk; medium-full is a pin.
 */
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module acq_rec_ctrl #(
    parameter int DEPTH_LOG2 = 6,
    parameter int unsigned SWITCH_WIN = acq_rec_pkg::SWITCH_WIN_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire acq_rec_pkg::apb_req_t apbReq,
    output acq_rec_pkg::apb_rsp_t apbRsp,
    input wire logic [29:0] sampleData,
    input wire logic sampleValid,
    input wire logic trigEvent,
    input wire logic mediaFullPin,
    output acq_rec_pkg::word_t strmData,
    output logic strmValid,
    input wire logic strmReady,
    output logic fastRate,
    output logic irq
);
    localparam int DEPTH = 1 << DEPTH_LOG2;
    localparam int EV_N = acq_rec_pkg::EV_N;

    logic [31:0] ctrl_r, mask_r, duration_r, history_r, sweepLen_r, rate_r;
    logic [EV_N-1:0] irqStat_r;
    acq_rec_pkg::state_t state_r;
    logic fullMeta_r, mediaFull_r;
    acq_rec_pkg::word_t mem_r [DEPTH];
    logic [DEPTH_LOG2:0] wrPtr_r, rdPtr_r;
    logic [31:0] samplePos_r, suspendPos_r, timer_r, histCnt_r;
    logic [31:0] sweepCnt_r, switchTotal_r, winCnt_r;
    logic [8:0] winSwitch_r;
    logic sweepActive_r, sweepUsed_r, pendEnd_r;
    logic [1:0] notePend_r;
    logic [EV_N-1:0] evSet;

    logic apbWr, apbRd;
    logic [7:0] addr;
    assign apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign apbRd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
    assign addr = apbReq.paddr[7:0];

    acq_rec_pkg::mode_t mode;
    assign mode = acq_rec_pkg::mode_t'(7'h01 << ctrl_r[acq_rec_pkg::CTRL_MODE_HI:acq_rec_pkg::CTRL_MODE_LO]);
    logic isCont, isSweep, running, capturing;
    assign isCont = mode inside {acq_rec_pkg::MODE_STANDARD, acq_rec_pkg::MODE_CIRCULAR,
                                 acq_rec_pkg::MODE_TIMED, acq_rec_pkg::MODE_STOPTRIG};
    assign isSweep = mode inside {acq_rec_pkg::MODE_MULTI, acq_rec_pkg::MODE_SLOWFAST};
    assign running = state_r == acq_rec_pkg::ST_RUN;
    assign capturing = running && sampleValid;

    // fifo occupancy
    logic [DEPTH_LOG2:0] used;
    logic fifoFull, fifoEmpty, push, pop;
    acq_rec_pkg::word_t pushWord;
    assign used = wrPtr_r - rdPtr_r;
    assign fifoFull = used == (DEPTH_LOG2+1)'(DEPTH);
    assign fifoEmpty = used == '0;
    // slow/fast needs sweepLen free; room test used by multi-sweep too
    logic sweepFits;
    assign sweepFits = (32'(DEPTH) - 32'(used)) >= sweepLen_r;

    logic trigHit, stopCond, userStop, userStart;
    assign trigHit = running && trigEvent;
    assign userStart = apbWr && addr == acq_rec_pkg::REG_CTRL && apbReq.pwdata[acq_rec_pkg::CTRL_START];
    assign userStop = apbWr && addr == acq_rec_pkg::REG_CTRL && apbReq.pwdata[acq_rec_pkg::CTRL_STOP];

    // stop conditions per mode
    always_comb begin
        stopCond = userStop;
        unique case (mode)
            acq_rec_pkg::MODE_STANDARD: stopCond = userStop || mediaFull_r;
            acq_rec_pkg::MODE_CIRCULAR: stopCond = userStop || trigHit;
            acq_rec_pkg::MODE_TIMED: stopCond = userStop || mediaFull_r
                                              || (timer_r >= duration_r);
            acq_rec_pkg::MODE_STOPTRIG: stopCond = userStop || mediaFull_r || trigHit;
            acq_rec_pkg::MODE_MULTI: stopCond = userStop || mediaFull_r;
            acq_rec_pkg::MODE_SLOWFAST: stopCond = userStop || mediaFull_r
                                                || (sweepUsed_r && !sweepActive_r);
            default: stopCond = 1'b1;
        endcase
    end

    // fifo push selection: notes, trigger markers, samples
    logic sweepGate, sampleAccept, trigMark;
    assign sweepGate = !isSweep || sweepActive_r;
    assign trigMark = trigHit && isSweep && !fifoFull;
    assign sampleAccept = capturing && sweepGate && !fifoFull && !trigMark && notePend_r == 2'h0;
    always_comb begin
        push = 1'b0;
        pushWord = '{tag: acq_rec_pkg::TAG_SAMPLE, payload: sampleData};
        if (notePend_r == 2'h2 && !fifoFull) begin
            push = 1'b1;
            pushWord = '{tag: acq_rec_pkg::TAG_OVR_BEGIN, payload: suspendPos_r[29:0]};
        end else if (notePend_r == 2'h1 && !fifoFull) begin
            push = 1'b1;
            pushWord = '{tag: acq_rec_pkg::TAG_OVR_END, payload: samplePos_r[29:0]};
        end else if (trigMark) begin
            push = 1'b1;
            pushWord = '{tag: acq_rec_pkg::TAG_TRIGGER, payload: samplePos_r[29:0]};
        end else if (sampleAccept) begin
            push = 1'b1;
        end
    end
    // drains in every state, suspend included
    assign pop = !fifoEmpty && (!strmValid || strmReady);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fullMeta_r <= 1'b0;
            mediaFull_r <= 1'b0;
        end else begin
            fullMeta_r <= mediaFullPin;
            mediaFull_r <= fullMeta_r;
        end
    end

    // fifo storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wrPtr_r[DEPTH_LOG2-1:0]] <= pushWord;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            strmValid <= 1'b0;
            strmData <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
                strmData <= mem_r[rdPtr_r[DEPTH_LOG2-1:0]];
                strmValid <= 1'b1;
            end else if (strmReady) begin
                strmValid <= 1'b0;
            end
        end
    end

    // recording state machine
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= acq_rec_pkg::ST_IDLE;
            suspendPos_r <= '0;
            notePend_r <= 2'h0;
            pendEnd_r <= 1'b0;
        end else begin
            if (push && notePend_r != 2'h0) begin
                notePend_r <= notePend_r - 2'h1;
            end
            unique case (state_r)
                acq_rec_pkg::ST_IDLE, acq_rec_pkg::ST_DONE: begin
                    if (userStart) begin
                        state_r <= acq_rec_pkg::ST_RUN;
                    end
                end
                acq_rec_pkg::ST_RUN: begin
                    if (stopCond) begin
                        state_r <= acq_rec_pkg::ST_DONE;
                    end else if (isCont && fifoFull && sampleValid) begin
                        state_r <= acq_rec_pkg::ST_SUSPEND;
                        suspendPos_r <= samplePos_r;
                    end
                end
                acq_rec_pkg::ST_SUSPEND: begin
                    if (userStop || mediaFull_r) begin
                        state_r <= acq_rec_pkg::ST_DONE;
                    end else if (fifoEmpty) begin
                        state_r <= acq_rec_pkg::ST_RUN;
                        notePend_r <= 2'h2;
                    end
                end
                default: state_r <= acq_rec_pkg::ST_IDLE;
            endcase
            pendEnd_r <= state_r == acq_rec_pkg::ST_RUN && stopCond;
        end
    end

    // position, timer and circular history counters
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            samplePos_r <= '0;
            timer_r <= '0;
            histCnt_r <= '0;
        end else if (userStart && !running) begin
            samplePos_r <= '0;
            timer_r <= '0;
            histCnt_r <= '0;
        end else begin
            if (running || state_r == acq_rec_pkg::ST_SUSPEND) begin
                timer_r <= timer_r + 32'h1;
                if (sampleValid) begin
                    samplePos_r <= samplePos_r + 32'h1;
                end
            end
            // history wraps so the medium address overwrites oldest data
            if (sampleAccept && mode == acq_rec_pkg::MODE_CIRCULAR) begin
                histCnt_r <= (histCnt_r + 32'h1 >= history_r) ? 32'h0 : histCnt_r + 32'h1;
            end
        end
    end

    // sweep window tracking
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sweepActive_r <= 1'b0;
            sweepUsed_r <= 1'b0;
            sweepCnt_r <= '0;
        end else if (userStart && !running) begin
            sweepActive_r <= 1'b0;
            sweepUsed_r <= 1'b0;
            sweepCnt_r <= '0;
        end else if (sweepActive_r) begin
            if (sampleAccept) begin
                sweepCnt_r <= sweepCnt_r + 32'h1;
                if (sweepCnt_r + 32'h1 >= sweepLen_r) begin
                    sweepActive_r <= 1'b0;
                end
            end
        end else if (trigHit && isSweep && sweepFits
                     && !(mode == acq_rec_pkg::MODE_SLOWFAST && sweepUsed_r)) begin
            sweepActive_r <= 1'b1;
            sweepUsed_r <= 1'b1;
            sweepCnt_r <= '0;
        end
    end

    // slow/fast rate switching with limits
    logic switchReq, switchOk, rateLegal;
    logic [15:0] slowDiv, fastDiv;
    assign slowDiv = rate_r[acq_rec_pkg::RATE_SLOW_LO +: 16];
    assign fastDiv = rate_r[acq_rec_pkg::RATE_FAST_LO +: 16];
    assign rateLegal = slowDiv >= 16'(fastDiv * acq_rec_pkg::SLOW_FAST_RATIO)
                    && slowDiv >= acq_rec_pkg::SLOW_DIV_MIN;
    assign switchReq = ctrl_r[acq_rec_pkg::CTRL_FAST_REQ] != fastRate;
    assign switchOk = switchReq && mode == acq_rec_pkg::MODE_SLOWFAST && sweepActive_r && rateLegal
                   && 32'(winSwitch_r) < acq_rec_pkg::SWITCH_PER_SEC
                   && switchTotal_r < acq_rec_pkg::SWITCH_MAX;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fastRate <= 1'b0;
            winCnt_r <= '0;
            winSwitch_r <= '0;
            switchTotal_r <= '0;
        end else begin
            if (winCnt_r >= SWITCH_WIN - 1) begin
                winCnt_r <= '0;
                winSwitch_r <= '0;
            end else begin
                winCnt_r <= winCnt_r + 32'h1;
                if (switchOk) begin
                    winSwitch_r <= winSwitch_r + 9'h1;
                end
            end
            if (userStart && !running) begin
                switchTotal_r <= '0;
            end else if (switchOk) begin
                fastRate <= !fastRate;
                switchTotal_r <= switchTotal_r + 32'h1;
            end
        end
    end

    // interrupt events
    always_comb begin
        evSet = '0;
        evSet[acq_rec_pkg::EV_DONE] = pendEnd_r;
        evSet[acq_rec_pkg::EV_OVERRUN] = running && isCont && fifoFull && sampleValid && !stopCond;
        evSet[acq_rec_pkg::EV_SWEEP_DROP] = trigHit && isSweep && !sweepActive_r && !sweepFits;
        evSet[acq_rec_pkg::EV_RESUME] = state_r == acq_rec_pkg::ST_SUSPEND && fifoEmpty;
        evSet[acq_rec_pkg::EV_RATE_ERR] = switchReq && mode == acq_rec_pkg::MODE_SLOWFAST && !rateLegal;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= acq_rec_pkg::CTRL_RST;
            mask_r <= acq_rec_pkg::MASK_RST;
            duration_r <= acq_rec_pkg::DURATION_RST;
            history_r <= acq_rec_pkg::HISTORY_RST;
            sweepLen_r <= acq_rec_pkg::SWEEP_LEN_RST;
            rate_r <= acq_rec_pkg::RATE_RST;
        end else if (apbWr) begin
            unique case (addr)
                acq_rec_pkg::REG_CTRL: ctrl_r <= apbReq.pwdata & 32'h0000_0170;
                acq_rec_pkg::REG_IRQ_MASK: mask_r <= apbReq.pwdata;
                acq_rec_pkg::REG_DURATION: duration_r <= apbReq.pwdata;
                acq_rec_pkg::REG_HISTORY: history_r <= apbReq.pwdata;
                acq_rec_pkg::REG_SWEEP_LEN: sweepLen_r <= apbReq.pwdata;
                acq_rec_pkg::REG_RATE: rate_r <= apbReq.pwdata;
                default: ;
            endcase
        end
    end

    // write-one-to-clear; a new event wins over the clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_r <= '0;
            irq <= 1'b0;
        end else begin
            if (apbWr && addr == acq_rec_pkg::REG_IRQ_STAT) begin
                irqStat_r <= (irqStat_r & ~apbReq.pwdata[EV_N-1:0]) | evSet;
            end else begin
                irqStat_r <= irqStat_r | evSet;
            end
            irq <= |(irqStat_r & mask_r[EV_N-1:0]);
        end
    end

    // read data captured in setup phase, pready in access phase
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            apbRsp <= '0;
        end else begin
            apbRsp.pready <= apbReq.psel && !apbReq.penable;
            apbRsp.pslverr <= apbReq.psel && !apbReq.penable && addr > acq_rec_pkg::REG_SWITCHES;
            if (apbRd) begin
                unique case (addr)
                    acq_rec_pkg::REG_CTRL: apbRsp.prdata <= ctrl_r;
                    acq_rec_pkg::REG_STATUS: apbRsp.prdata <= {20'h0, used[DEPTH_LOG2 -: 1], 3'h0,
                                                                fastRate, sweepActive_r, mediaFull_r,
                                                                fifoFull, state_r};
                    acq_rec_pkg::REG_IRQ_STAT: apbRsp.prdata <= 32'(irqStat_r);
                    acq_rec_pkg::REG_IRQ_MASK: apbRsp.prdata <= mask_r;
                    acq_rec_pkg::REG_DURATION: apbRsp.prdata <= duration_r;
                    acq_rec_pkg::REG_HISTORY: apbRsp.prdata <= history_r;
                    acq_rec_pkg::REG_SWEEP_LEN: apbRsp.prdata <= sweepLen_r;
                    acq_rec_pkg::REG_RATE: apbRsp.prdata <= rate_r;
                    acq_rec_pkg::REG_SWITCHES: apbRsp.prdata <= switchTotal_r;
                    default: apbRsp.prdata <= 32'h0000_0000;
                endcase
            end else if (!apbReq.psel) begin
                apbRsp.prdata <= 32'h0000_0000;
            end
        end
    end

    // checks
    property p_drop_keeps_marker;
        @(posedge core_clk) disable iff (!arst_n)
        (trigHit && isSweep && !sweepActive_r && !fifoFull) |-> push && pushWord.tag == acq_rec_pkg::TAG_TRIGGER;
    endproperty
    a_drop_keeps_marker: assert property (p_drop_keeps_marker) else $error("trigger marker lost");

    property p_no_sample_outside_sweep;
        @(posedge core_clk) disable iff (!arst_n)
        (isSweep && !sweepActive_r) |-> !sampleAccept;
    endproperty
    a_no_sample_outside_sweep: assert property (p_no_sample_outside_sweep) else $error("sample outside sweep");

    property p_sweep_restart;
        @(posedge core_clk) disable iff (!arst_n)
        (trigHit && mode == acq_rec_pkg::MODE_MULTI && !sweepActive_r && sweepFits && !userStart) |=> sweepActive_r;
    endproperty
    a_sweep_restart: assert property (p_sweep_restart) else $error("sweep not resumed");

    property p_switch_window;
        @(posedge core_clk) disable iff (!arst_n)
        32'(winSwitch_r) <= acq_rec_pkg::SWITCH_PER_SEC;
    endproperty
    a_switch_window: assert property (p_switch_window) else $error("switch rate exceeded");

    property p_switch_stop;
        @(posedge core_clk) disable iff (!arst_n)
        (!sweepActive_r) |=> $stable(fastRate);
    endproperty
    a_switch_stop: assert property (p_switch_stop) else $error("switch after sweep");

    sequence s_full_hit;
        running && isCont && fifoFull && sampleValid && !stopCond;
    endsequence
    property p_suspend;
        @(posedge core_clk) disable iff (!arst_n)
        s_full_hit |=> state_r == acq_rec_pkg::ST_SUSPEND;
    endproperty
    a_suspend: assert property (p_suspend) else $error("no suspend on full");

    sequence s_notes_out;
        (running && push && pushWord.tag == acq_rec_pkg::TAG_OVR_BEGIN)
        ##1 (push && pushWord.tag == acq_rec_pkg::TAG_OVR_END);
    endsequence
    property p_resume;
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == acq_rec_pkg::ST_SUSPEND && fifoEmpty && !userStop && !mediaFull_r) |=> s_notes_out;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");

    property p_drain;
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == acq_rec_pkg::ST_SUSPEND && !fifoEmpty && !strmValid) |-> pop;
    endproperty
    a_drain: assert property (p_drain) else $error("no drain in suspend");

    property p_stoptrig;
        @(posedge core_clk) disable iff (!arst_n)
        (running && trigEvent && mode == acq_rec_pkg::MODE_STOPTRIG) |=> state_r == acq_rec_pkg::ST_DONE;
    endproperty
    a_stoptrig: assert property (p_stoptrig) else $error("no stop on trigger");
endmodule // acq_rec_ctrl

// ### tb/storage_model.sv
/* storage medium model: takes stream words and counts overrun tags.
   assumes stall and full are steered by the bench. */
`timescale 1ns/1ps
module storage_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire acq_rec_pkg::word_t strmData,
    input wire logic strmValid,
    input wire logic stall,
    input wire logic full,
    output logic strmReady,
    output logic mediaFullPin,
    output int nBegin,
    output int nEnd,
    output logic [29:0] posBegin,
    output logic [29:0] posEnd
);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            strmReady <= 1'b0;
            mediaFullPin <= 1'b0;
            nBegin <= 0;
            nEnd <= 0;
            posBegin <= '0;
            posEnd <= '0;
        end else begin
            strmReady <= !stall;
            mediaFullPin <= full;
            if (strmValid && strmReady && strmData.tag == acq_rec_pkg::TAG_OVR_BEGIN) begin
                nBegin <= nBegin + 1;
                posBegin <= strmData.payload;
            end
            if (strmValid && strmReady && strmData.tag == acq_rec_pkg::TAG_OVR_END) begin
                nEnd <= nEnd + 1;
                posEnd <= strmData.payload;
            end
        end
    end
endmodule // storage_model

// ### tb/tb_top.sv
/* bench for the recording control: modes, overrun, irq over apb.
   assumes a storage model on the stream side. */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [31:0] ctrl; logic [1:0] ev;} row_t;
    logic core_clk = 1'b0;
    logic arst_n;
    acq_rec_pkg::apb_req_t apbReq = '0;
    acq_rec_pkg::apb_rsp_t apbRsp;
    acq_rec_pkg::word_t strmData;
    logic [29:0] sampleData = '0;
    logic sampleValid = 1'b0;
    logic trigEvent = 1'b0;
    logic stall = 1'b0;
    logic full = 1'b0;
    logic strmValid, strmReady, mediaFullPin, fastRate, irq, err;
    logic [31:0] rd;
    int nBegin, nEnd;
    logic [29:0] posBegin, posEnd;
    int miscompares = 0;
    int nChecks = 0;
    // end event: 0 stop, 1 trigger, 2 medium full, 3 duration
    row_t rows[8] = '{'{32'h21, 2'h2}, '{32'h21, 2'h0}, '{32'h31, 2'h1}, '{32'h31, 2'h0},
                      '{32'h41, 2'h3}, '{32'h41, 2'h2}, '{32'h51, 2'h1}, '{32'h51, 2'h2}};
    acq_rec_ctrl #(.DEPTH_LOG2(3), .SWITCH_WIN(1000)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .apbReq(apbReq), .apbRsp(apbRsp), .sampleData(sampleData), .sampleValid(sampleValid),
        .trigEvent(trigEvent), .mediaFullPin(mediaFullPin), .strmData(strmData),
        .strmValid(strmValid), .strmReady(strmReady), .fastRate(fastRate), .irq(irq));
    storage_model store_u (.core_clk(core_clk), .arst_n(arst_n), .strmData(strmData),
        .strmValid(strmValid), .stall(stall), .full(full), .strmReady(strmReady),
        .mediaFullPin(mediaFullPin), .nBegin(nBegin), .nEnd(nEnd), .posBegin(posBegin), .posEnd(posEnd));
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) sampleData <= sampleData + 30'h1;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apbReq <= '{32'(a), 1'b1, 1'b0, w, d};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        arst_n = 1'b0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        apb(0, acq_rec_pkg::REG_RATE, 32'h0);
        chk(rd, acq_rec_pkg::RATE_RST);
        apb(0, 8'h24, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1, acq_rec_pkg::REG_DURATION, 32'h14);
        for (int i = 0; i < 8; i++) begin
            apb(1, acq_rec_pkg::REG_CTRL, rows[i].ctrl);
            apb(0, acq_rec_pkg::REG_STATUS, 32'h0);
            chk(32'(rd[3:0]), 32'h2);
            case (rows[i].ev)
                2'h0: apb(1, acq_rec_pkg::REG_CTRL, {rows[i].ctrl[31:2], 2'b10});
                2'h1: begin
                    trigEvent <= 1'b1;
                    @(posedge core_clk);
                    trigEvent <= 1'b0;
                end
                2'h2: full <= 1'b1;
                default: ;
            endcase
            repeat (30) @(posedge core_clk);
            apb(0, acq_rec_pkg::REG_STATUS, 32'h0);
            chk(32'(rd[3:0]), 32'h8);
            full <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        $display("test modes done");
        apb(1, acq_rec_pkg::REG_IRQ_STAT, 32'h1F);
        stall <= 1'b1;
        apb(1, acq_rec_pkg::REG_CTRL, 32'h21);
        sampleValid <= 1'b1;
        repeat (20) @(posedge core_clk);
        apb(0, acq_rec_pkg::REG_STATUS, 32'h0);
        chk(32'(rd[3:0]), 32'h4);
        sampleValid <= 1'b0;
        stall <= 1'b0;
        repeat (40) @(posedge core_clk);
        apb(0, acq_rec_pkg::REG_STATUS, 32'h0);
        chk(32'(rd[3:0]), 32'h2);
        chk(32'(nBegin) | (32'(nEnd) << 4), 32'h11);
        chk(32'(posEnd > posBegin), 32'h1);
        apb(0, acq_rec_pkg::REG_IRQ_STAT, 32'h0);
        chk(rd & 32'hA, 32'hA);
        apb(1, acq_rec_pkg::REG_IRQ_MASK, 32'h2);
        @(posedge core_clk);
        chk(32'(irq), 32'h1);
        apb(1, acq_rec_pkg::REG_IRQ_STAT, 32'h1F);
        @(posedge core_clk);
        chk(32'(irq), 32'h0);
        $display("test overrun done");
        apb(1, acq_rec_pkg::REG_CTRL, 32'h22);
        apb(1, acq_rec_pkg::REG_RATE, 32'h0002_0010);
        apb(1, acq_rec_pkg::REG_SWEEP_LEN, 32'h4);
        apb(1, acq_rec_pkg::REG_CTRL, 32'h111);
        trigEvent <= 1'b1;
        @(posedge core_clk);
        trigEvent <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(32'(fastRate), 32'h1);
        sampleValid <= 1'b1;
        repeat (8) @(posedge core_clk);
        sampleValid <= 1'b0;
        apb(1, acq_rec_pkg::REG_CTRL, 32'h10);
        apb(0, acq_rec_pkg::REG_STATUS, 32'h0);
        chk(32'(rd[7:0]), 32'h88);
        apb(0, acq_rec_pkg::REG_SWITCHES, 32'h0);
        chk(rd, 32'h1);
        $display("test slow fast done");
        results();
    end
endmodule // tb_top
